//--- pkg/ebt_defs.vh
// constants for the external bus timing configuration block
`ifndef EBT_DEFS_VH
`define EBT_DEFS_VH
`define EBT_OFF_SYSCFG     8'h00
`define EBT_OFF_STATUS     8'h01
`define EBT_OFF_ACCESS     8'h02
`define EBT_POS_WAIT_LO    0
`define EBT_POS_WAIT_HI    3
`define EBT_POS_STRB_DLY   4
`define EBT_POS_TRI_EXT    5
`define EBT_POS_BUS_TYPE_FIELD_LO    6
`define EBT_POS_BUS_TYPE_FIELD_HI    7
`define EBT_POS_SEG_OFF    11
`define EBT_POS_RDY_EN     12
`define EBT_SYSCFG_RESET   16'h0000
`define EBT_SYSCFG_WMASK   16'h7FFF
`define EBT_BUS_TYPE_FIELD_DEMUX     2'h3
`define EBT_BUS_TYPE_FIELD_MUX8      2'h1
`define EBT_BUS_TYPE_FIELD_MUX16     2'h2
`define EBT_OSC_PER_STATE  2
`define EBT_WAIT_MAX       4'hF
`endif

//--- hdl/ebt_timing.v
// external bus timing configuration register and bus cycle timer
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`include "ebt_defs.vh"
module ebt_timing (
    // clock, reset, enable
    input  wire        clk_sys_in,
    input  wire        rst_b_in,
    input  wire        ce_in,
    // register port
    input  wire [7:0]  reg_addr_in,
    input  wire [15:0] reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [15:0] reg_rdata_out,
    // bus cycle request
    input  wire        cyc_start_in,
    input  wire        cyc_external_in,
    input  wire        ready_b_in,
    output reg         cyc_busy_out,
    output reg         cyc_done_out,
    output reg         addr_latch_out,
    output reg         strobe_out,
    output reg         tristate_out,
    // pin functions
    output reg         seg_addr_en_out,
    output reg         ready_pin_en_out
);
    // one state time is two clock cycles
    localparam ST_IDLE = 3'h0;
    localparam ST_ALE  = 3'h1;
    localparam ST_WAIT = 3'h2;
    localparam ST_RDY  = 3'h3;
    localparam ST_TRI  = 3'h4;

    reg [15:0] syscfg_ff;
    reg [15:0] nxt_syscfg;
    reg [2:0]  state_ff;
    reg [2:0]  nxt_state;
    reg [5:0]  cnt_ff;
    reg [5:0]  nxt_cnt;
    reg        rdy_s1_ff;
    reg        rdy_s2_ff;
    reg        ext_ff;
    reg        nxt_ext;
    reg        delay_ff;
    reg        nxt_delay;
    reg [15:0] nxt_rdata;

    wire [3:0] wait_fld = syscfg_ff[`EBT_POS_WAIT_HI:`EBT_POS_WAIT_LO];
    wire [1:0] bus_type_field     = syscfg_ff[`EBT_POS_BUS_TYPE_FIELD_HI:`EBT_POS_BUS_TYPE_FIELD_LO];
    wire       rdy_en   = syscfg_ff[`EBT_POS_RDY_EN];
    wire       rdy_async = wait_fld[0];

    // cycles for a number of state times
    function [5:0] st2cyc;
        input [4:0] st;
        begin
            st2cyc = {st, 1'b0};
        end
    endfunction

    function [4:0] tri_states;
        input [15:0] cfg;
        reg   [1:0]  bt;
        begin
            bt = cfg[`EBT_POS_BUS_TYPE_FIELD_HI:`EBT_POS_BUS_TYPE_FIELD_LO];
            tri_states = {4'h0, ~cfg[`EBT_POS_TRI_EXT]} +
                {4'h0, (bt == `EBT_BUS_TYPE_FIELD_MUX8) || (bt == `EBT_BUS_TYPE_FIELD_MUX16)};
        end
    endfunction

    // a zero tri-state time skips the tri state, so no empty clock is added
    wire [5:0] tri_cyc  = st2cyc(tri_states(syscfg_ff));
    wire [2:0] tri_next = (tri_cyc == 6'h00) ? ST_IDLE : ST_TRI;

    // async mode adds a two-stage sync; sync mode samples the pin directly
    // the sync stages already hold ready as active high
    wire rdy_seen = rdy_async ? rdy_s2_ff : ~ready_b_in;

    always @* begin
        nxt_syscfg = syscfg_ff;
        if (reg_wr_in && reg_addr_in == `EBT_OFF_SYSCFG) begin
            nxt_syscfg = reg_wdata_in & `EBT_SYSCFG_WMASK;
        end
    end

    always @* begin
        nxt_rdata = 16'h0000;
        if (reg_rd_in) begin
            case (reg_addr_in)
                `EBT_OFF_SYSCFG: nxt_rdata = syscfg_ff;
                `EBT_OFF_STATUS: nxt_rdata = {13'h0000, state_ff};
                `EBT_OFF_ACCESS: nxt_rdata = {10'h000, cnt_ff};
                default:         nxt_rdata = 16'h0000;
            endcase
        end
    end

    always @* begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_ext   = ext_ff;
        nxt_delay = delay_ff;
        case (state_ff)
            ST_IDLE: begin
                if (cyc_start_in) begin
                    nxt_ext   = cyc_external_in;
                    nxt_delay = ~syscfg_ff[`EBT_POS_STRB_DLY];
                    nxt_cnt   = st2cyc(5'h01) - 6'h01;
                    nxt_state = ST_ALE;
                end
            end
            ST_ALE: begin
                if (cnt_ff != 6'h00) begin
                    nxt_cnt = cnt_ff - 6'h01;
                end else if (!ext_ff) begin
                    nxt_state = ST_IDLE;
                end else if (rdy_en) begin
                    nxt_state = ST_RDY;
                end else if (wait_fld == `EBT_WAIT_MAX) begin
                    nxt_cnt   = tri_cyc;
                    nxt_state = tri_next;
                end else begin
                    nxt_cnt   = st2cyc({1'b0, ~wait_fld}) - 6'h01;
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (cnt_ff != 6'h00) begin
                    nxt_cnt = cnt_ff - 6'h01;
                end else begin
                    nxt_cnt   = tri_cyc;
                    nxt_state = tri_next;
                end
            end
            ST_RDY: begin
                // no timeout: a missing ready holds the cycle until reset
                if (rdy_seen) begin
                    nxt_cnt   = tri_cyc;
                    nxt_state = tri_next;
                end
            end
            ST_TRI: begin
                if (cnt_ff > 6'h01) begin
                    nxt_cnt = cnt_ff - 6'h01;
                end else begin
                    nxt_cnt   = 6'h00;
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
        if (state_ff == ST_TRI && cnt_ff == 6'h00) begin
            nxt_state = ST_IDLE;
        end
    end

    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            syscfg_ff        <= `EBT_SYSCFG_RESET;
            state_ff         <= ST_IDLE;
            cnt_ff           <= 6'h00;
            ext_ff           <= 1'b0;
            delay_ff         <= 1'b0;
            rdy_s1_ff        <= 1'b0;
            rdy_s2_ff        <= 1'b0;
            reg_rdata_out    <= 16'h0000;
            cyc_busy_out     <= 1'b0;
            cyc_done_out     <= 1'b0;
            addr_latch_out   <= 1'b0;
            strobe_out       <= 1'b0;
            tristate_out     <= 1'b0;
            seg_addr_en_out  <= 1'b0;
            ready_pin_en_out <= 1'b0;
        end else if (ce_in) begin
            syscfg_ff        <= nxt_syscfg;
            state_ff         <= nxt_state;
            cnt_ff           <= nxt_cnt;
            ext_ff           <= nxt_ext;
            delay_ff         <= nxt_delay;
            rdy_s1_ff        <= ~ready_b_in;
            rdy_s2_ff        <= rdy_s1_ff;
            reg_rdata_out    <= nxt_rdata;
            cyc_busy_out     <= (nxt_state != ST_IDLE);
            cyc_done_out     <= (state_ff != ST_IDLE) && (nxt_state == ST_IDLE);
            addr_latch_out   <= (nxt_state == ST_ALE);
            // delay only trims the strobe's leading half state; its end is fixed
            strobe_out       <= ((nxt_state == ST_ALE) && nxt_ext && !nxt_delay
                                 && nxt_cnt == 6'h00)
                                || (nxt_state == ST_WAIT) || (nxt_state == ST_RDY)
                                || ((state_ff == ST_ALE) && (nxt_state != ST_ALE)
                                    && nxt_state != ST_IDLE);
            tristate_out     <= (nxt_state == ST_TRI);
            seg_addr_en_out  <= ~nxt_syscfg[`EBT_POS_SEG_OFF];
            ready_pin_en_out <= nxt_syscfg[`EBT_POS_RDY_EN];
        end
    end
endmodule

//--- verification/ebt_mem.sv
// far-side memory model that answers each strobe held longer than lag_in clocks with active-low ready
`timescale 1ns/10ps
module ebt_mem (
    input  wire       clk_sys_in,
    input  wire       strobe_in,
    input  wire [3:0] lag_in,
    output reg        ready_b_out
);
    reg [3:0] cnt_ff = 4'h0;
    initial ready_b_out = 1'h1;
    always @(posedge clk_sys_in) begin
        cnt_ff <= strobe_in ? cnt_ff + 4'h1 : 4'h0;
        // pulled up between accesses, low after lag clocks of strobe
        ready_b_out <= !(strobe_in && cnt_ff >= lag_in);
    end
endmodule

//--- verification/ebt_timing_assertions.sv
// port-level assertions for the bus timing block
`timescale 1ns/10ps
module ebt_chk (
    input wire        clk_sys_in,
    input wire        rst_b_in,
    input wire [7:0]  reg_addr_in,
    input wire [15:0] reg_wdata_in,
    input wire        reg_wr_in,
    input wire        reg_rd_in,
    input wire [15:0] reg_rdata_out,
    input wire        cyc_start_in,
    input wire        cyc_external_in,
    input wire        cyc_busy_out,
    input wire        cyc_done_out,
    input wire        addr_latch_out,
    input wire        strobe_out,
    input wire        tristate_out,
    input wire        seg_addr_en_out,
    input wire        ready_pin_en_out
);
    reg  [15:0] sh_ff, cfg_ff;
    reg         ext_ff;
    reg  [9:0]  cnt_ff;
    wire        taken = cyc_start_in && !cyc_busy_out && !cyc_done_out;
    wire [9:0]  tri_n = !cfg_ff[5] + (cfg_ff[7:6] == 2'h1 || cfg_ff[7:6] == 2'h2);
    wire [9:0]  exp_len = ext_ff ? 10'h3 + 10'h2 * (10'hF - cfg_ff[3:0] + tri_n) : 10'h3;
    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sh_ff <= 16'h0000;
            cfg_ff <= 16'h0000;
            ext_ff <= 1'h0;
            cnt_ff <= 10'h0;
        end else begin
            if (reg_wr_in && reg_addr_in == 8'h00) sh_ff <= reg_wdata_in & 16'h7FFF;
            if (taken) cfg_ff <= sh_ff;
            if (taken) ext_ff <= cyc_external_in;
            cnt_ff <= taken ? 10'h1 : cnt_ff + 10'h1;
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    a_read_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
        else $error("read data outside read slot");
    a_done_pulse: assert property (cyc_done_out |=> !cyc_done_out && !cyc_busy_out)
        else $error("done longer than one cycle");
    a_ale_two: assert property ($rose(cyc_busy_out) |-> addr_latch_out[*2] ##1 !addr_latch_out)
        else $error("latch strobe not one state");
    a_start_busy: assert property (taken |=> cyc_busy_out) else $error("start not taken");
    a_seg_pin: assert property ($past(rst_b_in) |-> seg_addr_en_out == !sh_ff[11])
        else $error("segment pins wrong");
    a_ready_pin: assert property ($past(rst_b_in) |-> ready_pin_en_out == sh_ff[12])
        else $error("ready pin wrong");
    a_cycle_len: assert property (
        cyc_done_out && !(cfg_ff[12] && ext_ff) |-> cnt_ff == exp_len)
        else $error("cycle length wrong");
    a_strobe_delay: assert property (
        $fell(addr_latch_out) && ext_ff |-> $past(strobe_out) == cfg_ff[4])
        else $error("strobe delay wrong");
    a_tri_owned: assert property (tristate_out |-> cyc_busy_out && ext_ff)
        else $error("tri-state time outside external cycle");
    a_tri_span: assert property ($rose(tristate_out) |-> tristate_out[*2])
        else $error("tri-state time shorter than one state");
    c_ready: cover property (cyc_done_out && ext_ff && cfg_ff[12]);
    c_onchip: cover property (cyc_done_out && !ext_ff);
    c_mux: cover property (cyc_done_out && ext_ff && cfg_ff[7:6] == 2'h1);
endmodule
bind ebt_timing ebt_chk u_chk (.clk_sys_in, .rst_b_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .cyc_start_in, .cyc_external_in, .cyc_busy_out,
    .cyc_done_out, .addr_latch_out, .strobe_out, .tristate_out, .seg_addr_en_out,
    .ready_pin_en_out);

//--- verification/test_ebt_timing.sv
// self-checking bench for the bus timing block
`timescale 1ns/10ps
module test_ebt_timing;
    reg clk_sys_in = 1'h0, rst_b_in = 1'h0, reg_wr_in = 1'h0, reg_rd_in = 1'h0, e;
    reg cyc_start_in = 1'h0, cyc_external_in = 1'h0;
    reg  [7:0]  reg_addr_in = 8'h00;
    reg  [15:0] reg_wdata_in = 16'h0000, c;
    reg  [3:0]  lag = 4'h1;
    wire [15:0] reg_rdata_out;
    wire ready_b_in, cyc_busy_out, cyc_done_out, addr_latch_out, strobe_out;
    wire tristate_out, seg_addr_en_out, ready_pin_en_out;
    integer error_cnt = 0, n_compared = 0, i, n, m;
    always #50 clk_sys_in = ~clk_sys_in;
    ebt_mem u_mem (.clk_sys_in, .strobe_in(strobe_out), .lag_in(lag), .ready_b_out(ready_b_in));
    ebt_timing DUT (.clk_sys_in, .rst_b_in, .ce_in(1'h1), .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .cyc_start_in, .cyc_external_in, .ready_b_in,
        .cyc_busy_out, .cyc_done_out, .addr_latch_out, .strobe_out, .tristate_out,
        .seg_addr_en_out, .ready_pin_en_out);
    // negedges from start to seen done; on-chip cycles ignore the config
    function integer model(input [15:0] k, input x);
        model = x ? 3 + 2 * (15 - k[3:0] + !k[5] + (k[7:6] == 2'h1 || k[7:6] == 2'h2)) : 3;
    endfunction
    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task acc(input [7:0] a, input [15:0] d, input w);
        begin
            @(posedge clk_sys_in);
            reg_addr_in <= a;
            reg_wdata_in <= d;
            reg_wr_in <= w;
            reg_rd_in <= !w;
            @(posedge clk_sys_in);
            reg_wr_in <= 1'h0;
            reg_rd_in <= 1'h0;
            @(negedge clk_sys_in);
            if (!w) chk(reg_rdata_out, d);
        end
    endtask
    task cyc(input x, output integer len);
        begin
            @(posedge clk_sys_in);
            cyc_start_in <= 1'h1;
            cyc_external_in <= x;
            @(posedge clk_sys_in);
            cyc_start_in <= 1'h0;
            len = 0;
            while (cyc_done_out !== 1'h1 && len < 400) begin
                @(negedge clk_sys_in);
                len = len + 1;
            end
        end
    endtask
    task give_verdict;
        begin
            $display("compared %0d, errors %0d", n_compared, error_cnt);
            if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    initial begin
        void'($urandom(27));
        repeat (3) @(posedge clk_sys_in);
        rst_b_in <= 1'h1;
        acc(8'h00, 16'h0000, 1'h0);
        chk(seg_addr_en_out, 16'h0001);
        for (i = 0; i < 24; i = i + 1) begin
            c = (i < 16) ? i * 16'h0011 : $urandom & 16'h0FFF;
            e = (i < 16) ? 1'h1 : $urandom;
            acc(8'h00, c, 1'h1);
            acc(8'h00, c, 1'h0);
            cyc(e, n);
            chk(n, model(c, e));
            chk(seg_addr_en_out, !c[11]);
        end
        acc(8'h01, 16'h0000, 1'h0);
        acc(8'h02, 16'h0000, 1'h0);
        acc(8'h07, 16'h1234, 1'h1);
        acc(8'h07, 16'h0000, 1'h0);
        acc(8'h00, 16'hFFFF, 1'h1);
        acc(8'h00, 16'h7FFF, 1'h0);
        chk(ready_pin_en_out, 16'h0001);
        acc(8'h00, 16'h1000, 1'h1);
        cyc(1'h1, n);
        chk(n < model(16'h1000, 1'h1), 16'h0001);
        acc(8'h00, 16'h1001, 1'h1);
        cyc(1'h1, m);
        chk(m > n, 16'h0001);
        lag = 4'h4;
        acc(8'h00, 16'h1000, 1'h1);
        cyc(1'h1, m);
        chk(m > n, 16'h0001);
        give_verdict;
    end
    // about 30 transfers of at most 60 clocks each, with wide margin
    initial begin
        #3000000;
        error_cnt = error_cnt + 1;
        give_verdict;
    end
endmodule
